// *** emc_pkg.sv ***
// Package: register map, field positions, reset values for the mode config bank
package emc_pkg;
    // Indirect address width and data width
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 16;
    // Register offsets
    localparam logic [6:0] ADDR_PERIOD    = 7'h0a;
    localparam logic [6:0] ADDR_CFG_A     = 7'h0b;
    localparam logic [6:0] ADDR_CFG_B     = 7'h0c;
    localparam logic [6:0] ADDR_VAR_SCALE = 7'h25;
    localparam logic [6:0] ADDR_VA_SCALE  = 7'h26;
    localparam logic [6:0] ADDR_PA_NUM    = 7'h27;
    localparam logic [6:0] ADDR_PA_DEN    = 7'h28;
    localparam logic [6:0] ADDR_PB_NUM    = 7'h29;
    localparam logic [6:0] ADDR_PB_DEN    = 7'h2a;
    localparam logic [6:0] ADDR_RSV_0     = 7'h3b;
    localparam logic [6:0] ADDR_RSV_1     = 7'h3c;
    localparam logic [6:0] ADDR_CAL_MODE  = 7'h3d;
    localparam logic [6:0] ADDR_RSV_2     = 7'h3e;
    localparam logic [6:0] ADDR_RSV_3     = 7'h3f;
    // Reset values
    localparam logic [7:0]  RST_CFG_A = 8'h06;
    localparam logic [7:0]  RST_CFG_B = 8'h40;
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_NUM   = 16'h0000;
    localparam logic [15:0] RST_DEN   = 16'h003f;
    localparam logic [15:0] RST_RSV_1 = 16'h0300;
    localparam logic [15:0] RST_RSV   = 16'h0000;
    // Field positions in the first mode register
    localparam int unsigned A_SOFT_RST   = 7;
    localparam int unsigned A_ZX_BYPASS  = 6;
    localparam int unsigned A_INTEG      = 5;
    localparam int unsigned A_SWAP       = 4;
    localparam int unsigned A_ADC_POWER_DOWN      = 3;
    localparam int unsigned A_PB_DIS     = 2;
    localparam int unsigned A_PA_DIS     = 1;
    localparam int unsigned A_HPF_BYPASS = 0;
    // Field positions in the second mode register
    localparam int unsigned B_PB_SRC_HI  = 7;
    localparam int unsigned B_PB_SRC_LO  = 6;
    localparam int unsigned B_PA_SRC_HI  = 5;
    localparam int unsigned B_PA_SRC_LO  = 4;
    localparam int unsigned B_IRMS_SEL   = 3;
    localparam int unsigned B_ZX_RMS     = 2;
    localparam int unsigned B_FREQ_SEL   = 1;
    localparam int unsigned B_WAVE_EN    = 0;
    // Resolved pulse source quantities
    typedef enum logic [1:0] {
        EMC_SRC_ACTIVE   = 2'h0,
        EMC_SRC_REACTIVE = 2'h1,
        EMC_SRC_APPARENT = 2'h2,
        EMC_SRC_IRMS     = 2'h3
    } emc_src_t;
    // Bus cycle states
    typedef enum logic [2:0] {
        EMC_ST_IDLE  = 3'b001,
        EMC_ST_WRITE = 3'b010,
        EMC_ST_READ  = 3'b100
    } emc_state_t;
endpackage

// *** emc_src_decode.sv ***
// Pulse output source decoder: maps a 2-bit select to a quantity
`timescale 1ns/1ps
module emc_src_decode
    import emc_pkg::*;
(
    // Select inputs
    input  wire logic [1:0] sel_i,
    input  wire logic       irms_sel_i,
    // Decoded quantity
    output emc_src_t        src_o
);
    // Code 1X picks apparent power or current rms per the shared bit
    assign src_o = sel_i[1] ? (irms_sel_i ? EMC_SRC_IRMS : EMC_SRC_APPARENT)
                 : (sel_i[0] ? EMC_SRC_REACTIVE : EMC_SRC_ACTIVE);
endmodule

// *** emc_rd_mux.sv ***
// Read data selector for the mode config register bank
`timescale 1ns/1ps
module emc_rd_mux
    import emc_pkg::*;
(
    // Address and register contents
    input  wire logic [6:0]  addr_i,
    input  wire logic [7:0]  cfg_a_i,
    input  wire logic [7:0]  cfg_b_i,
    input  wire logic [7:0]  var_scale_i,
    input  wire logic [7:0]  va_scale_i,
    input  wire logic [15:0] pa_num_i,
    input  wire logic [15:0] pa_den_i,
    input  wire logic [15:0] pb_num_i,
    input  wire logic [15:0] pb_den_i,
    input  wire logic [7:0]  cal_mode_i,
    input  wire logic [15:0] rsv0_i,
    input  wire logic [15:0] rsv1_i,
    input  wire logic [15:0] rsv2_i,
    input  wire logic [15:0] rsv3_i,
    input  wire logic [15:0] period_i,
    // Selected data and hit flag
    output logic [15:0]      data_o,
    output logic             hit_o
);
    // Byte-wide registers read with zero in the upper byte
    always_comb begin
        data_o = 16'h0000;
        hit_o  = 1'b1;
        case (addr_i)
            ADDR_PERIOD:    data_o = period_i;
            ADDR_CFG_A:     data_o = {8'h00, cfg_a_i};
            ADDR_CFG_B:     data_o = {8'h00, cfg_b_i};
            ADDR_VAR_SCALE: data_o = {8'h00, var_scale_i};
            ADDR_VA_SCALE:  data_o = {8'h00, va_scale_i};
            ADDR_PA_NUM:    data_o = pa_num_i;
            ADDR_PA_DEN:    data_o = pa_den_i;
            ADDR_PB_NUM:    data_o = pb_num_i;
            ADDR_PB_DEN:    data_o = pb_den_i;
            ADDR_CAL_MODE:  data_o = {8'h00, cal_mode_i};
            ADDR_RSV_0:     data_o = rsv0_i;
            ADDR_RSV_1:     data_o = rsv1_i;
            ADDR_RSV_2:     data_o = rsv2_i;
            ADDR_RSV_3:     data_o = rsv3_i;
            default:        hit_o  = 1'b0;
        endcase
    end
endmodule

// *** emc_mode_config.sv ***
// Mode configuration register bank of the metering core
// Operation
// - Soft reset bit restores all defaults except the address pointer
// - Bit 6 bypasses zero-cross low-pass filter
// - Bit 5 inserts current-path integrator
// - Bit 4 swaps the two ADC channels
// - Bit 3 powers down both ADCs
// - Bit 2 defaults set, disables pulse B
// - Bit 1 defaults set, disables pulse A
// - Bit 0 bypasses both high-pass filters
// - Bits 7:6 select pulse B source
// - Bits 5:4 select pulse A source
// - Bit 3 picks apparent or current rms
// - Bit 2 syncs rms updates to crossings
// - Bit 1 picks period or frequency result
// - Bit 0 enables waveform sampling, default clear
// - Pulse numerators reset zero, denominators 0x3f
// - Reactive, apparent scale registers, reset zero
// - Apparent accumulator takes rms when selected
`timescale 1ns/1ps
module emc_mode_config
    import emc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Indirect register port from the microcontroller
    input  wire logic [ADDR_W-1:0] ptr_wr_i,
    input  wire logic [ADDR_W-1:0] ptr_data_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0]      rdata_o,
    output logic                   rvalid_o,
    output logic                   rerr_o,
    output logic [ADDR_W-1:0]      ptr_o,
    // Line period and frequency measurements from the datapath
    input  wire logic [15:0]       line_period_i,
    input  wire logic [15:0]       line_freq_i,
    // Datapath controls from the first mode register
    output logic                   zero_cross_filter_bypass_o,
    output logic                   integrator_enable_o,
    output logic                   adc_channel_swap_o,
    output logic                   adc_power_down_o,
    output logic                   pulse_b_disable_o,
    output logic                   pulse_a_disable_o,
    output logic                   highpass_bypass_o,
    // Datapath controls from the second mode register, and the soft reset pulse from the first
    output emc_src_t               pulse_a_source_o,
    output emc_src_t               pulse_b_source_o,
    output logic                   apparent_accum_irms_o,
    output logic                   rms_zero_cross_sync_o,
    output logic                   waveform_sampling_enable_o,
    output logic                   soft_reset_pulse_o,
    // Scaling values
    output logic [7:0]             reactive_energy_scale_o,
    output logic [7:0]             apparent_energy_scale_o,
    output logic [15:0]            pulse_a_numerator_o,
    output logic [15:0]            pulse_a_denominator_o,
    output logic [15:0]            pulse_b_numerator_o,
    output logic [15:0]            pulse_b_denominator_o,
    output logic [7:0]             calibration_mode_select_o
);
    import emc_pkg::*;

    // Address pointer and bus state
    logic [ADDR_W-1:0] metering_address_pointer_r;
    emc_state_t        state_r;
    emc_state_t        state_nxt;

    // Register file
    logic [7:0]  measure_config_a_r;
    logic [7:0]  measure_config_b_r;
    logic [7:0]  reactive_energy_scale_r;
    logic [7:0]  apparent_energy_scale_r;
    logic [15:0] pulse_a_numerator_r;
    logic [15:0] pulse_a_denominator_r;
    logic [15:0] pulse_b_numerator_r;
    logic [15:0] pulse_b_denominator_r;
    logic [7:0]  calibration_mode_select_r;
    logic [15:0] reserved_r [4];

    // Output stage registers
    logic [DATA_W-1:0] rdata_r;
    logic              rvalid_r;
    logic              rerr_r;
    logic              soft_reset_r;
    emc_src_t          pa_src_r;
    emc_src_t          pb_src_r;

    // Decode wires
    wire logic        sel_cfg_a;
    wire logic        sel_cfg_b;
    wire logic        soft_rst_req;
    wire logic        any_rst;
    wire logic [15:0] rd_data;
    wire logic        rd_hit;
    wire logic [15:0] period_result;
    emc_src_t         pa_src;
    emc_src_t         pb_src;

    // Function: write strobe for a given register address
    function automatic logic wr_hit(input logic [6:0] a,
                                    input logic [6:0] ptr,
                                    input logic       we);
        wr_hit = we && (ptr == a);
    endfunction

    assign sel_cfg_a = wr_hit(ADDR_CFG_A, ptr_o, wr_i);
    assign sel_cfg_b = wr_hit(ADDR_CFG_B, ptr_o, wr_i);

    // soft reset request
    // Writing the bit is a command; the bank reloads, so the bit reads 0
    assign soft_rst_req = sel_cfg_a && wdata_i[A_SOFT_RST];
    assign any_rst      = rst_i || soft_rst_req;

    assign period_result = measure_config_b_r[B_FREQ_SEL] ? line_freq_i
                                                          : line_period_i;

    // Source decoders share the one rms select bit, so A and B can conflict
    // pulse A source
    emc_src_decode u_pa_dec (
        .sel_i      (measure_config_b_r[B_PA_SRC_HI:B_PA_SRC_LO]),
        .irms_sel_i (measure_config_b_r[B_IRMS_SEL]),
        .src_o      (pa_src)
    );
    emc_src_decode u_pb_dec (
        .sel_i      (measure_config_b_r[B_PB_SRC_HI:B_PB_SRC_LO]),
        .irms_sel_i (measure_config_b_r[B_IRMS_SEL]),
        .src_o      (pb_src)
    );

    // Read data mux
    emc_rd_mux u_rd_mux (
        .addr_i      (ptr_o),
        .cfg_a_i     (measure_config_a_r),
        .cfg_b_i     (measure_config_b_r),
        .var_scale_i (reactive_energy_scale_r),
        .va_scale_i  (apparent_energy_scale_r),
        .pa_num_i    (pulse_a_numerator_r),
        .pa_den_i    (pulse_a_denominator_r),
        .pb_num_i    (pulse_b_numerator_r),
        .pb_den_i    (pulse_b_denominator_r),
        .cal_mode_i  (calibration_mode_select_r),
        .rsv0_i      (reserved_r[0]),
        .rsv1_i      (reserved_r[1]),
        .rsv2_i      (reserved_r[2]),
        .rsv3_i      (reserved_r[3]),
        .period_i    (period_result),
        .data_o      (rd_data),
        .hit_o       (rd_hit)
    );

    // Bus state: record what kind of access happens this cycle
    always_comb begin
        case (state_r)
            EMC_ST_IDLE, EMC_ST_WRITE, EMC_ST_READ: begin
                if (wr_i) begin
                    state_nxt = EMC_ST_WRITE;
                end else if (rd_i) begin
                    state_nxt = EMC_ST_READ;
                end else begin
                    state_nxt = EMC_ST_IDLE;
                end
            end
            default: state_nxt = EMC_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= EMC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // pointer load
    // Pointer is the bus master's; soft reset of the bank leaves it alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            metering_address_pointer_r <= '0;
        end else if (|ptr_wr_i) begin
            metering_address_pointer_r <= ptr_data_i;
        end
    end

    // reset value sets both pulse disables
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            measure_config_a_r <= RST_CFG_A;
            measure_config_b_r <= RST_CFG_B;
        end else begin
            if (sel_cfg_a) begin
                measure_config_a_r <= wdata_i[7:0];
            end
            if (sel_cfg_b) begin
                measure_config_b_r <= wdata_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            reactive_energy_scale_r <= RST_BYTE;
            apparent_energy_scale_r <= RST_BYTE;
            calibration_mode_select_r <= RST_BYTE;
        end else begin
            if (wr_hit(ADDR_VAR_SCALE, ptr_o, wr_i)) begin
                reactive_energy_scale_r <= wdata_i[7:0];
            end
            if (wr_hit(ADDR_VA_SCALE, ptr_o, wr_i)) begin
                apparent_energy_scale_r <= wdata_i[7:0];
            end
            if (wr_hit(ADDR_CAL_MODE, ptr_o, wr_i)) begin
                calibration_mode_select_r <= wdata_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            pulse_a_numerator_r   <= RST_NUM;
            pulse_a_denominator_r <= RST_DEN;
            pulse_b_numerator_r   <= RST_NUM;
            pulse_b_denominator_r <= RST_DEN;
        end else begin
            if (wr_hit(ADDR_PA_NUM, ptr_o, wr_i)) begin
                pulse_a_numerator_r <= wdata_i;
            end
            if (wr_hit(ADDR_PA_DEN, ptr_o, wr_i)) begin
                pulse_a_denominator_r <= wdata_i;
            end
            if (wr_hit(ADDR_PB_NUM, ptr_o, wr_i)) begin
                pulse_b_numerator_r <= wdata_i;
            end
            if (wr_hit(ADDR_PB_DEN, ptr_o, wr_i)) begin
                pulse_b_denominator_r <= wdata_i;
            end
        end
    end

    // Reserved registers stay writable; software must keep defaults
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            reserved_r[0] <= RST_RSV;
            reserved_r[1] <= RST_RSV_1;
            reserved_r[2] <= RST_RSV;
            reserved_r[3] <= RST_RSV;
        end else begin
            if (wr_hit(ADDR_RSV_0, ptr_o, wr_i)) begin
                reserved_r[0] <= wdata_i;
            end
            if (wr_hit(ADDR_RSV_1, ptr_o, wr_i)) begin
                reserved_r[1] <= wdata_i;
            end
            if (wr_hit(ADDR_RSV_2, ptr_o, wr_i)) begin
                reserved_r[2] <= wdata_i;
            end
            if (wr_hit(ADDR_RSV_3, ptr_o, wr_i)) begin
                reserved_r[3] <= wdata_i;
            end
        end
    end

    // Read response: one cycle after rd_i when wr_i is low, unmapped reads flag an error
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
            rerr_r   <= 1'b0;
        end else begin
            rvalid_r <= rd_i && !wr_i;
            rerr_r   <= rd_i && !wr_i && !rd_hit;
            rdata_r  <= (rd_i && !wr_i && rd_hit) ? rd_data : '0;
        end
    end

    // Registered decoded sources and soft reset pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_src_r     <= EMC_SRC_ACTIVE;
            pb_src_r     <= EMC_SRC_REACTIVE;
            soft_reset_r <= 1'b0;
        end else begin
            pa_src_r     <= pa_src;
            pb_src_r     <= pb_src;
            soft_reset_r <= soft_rst_req;
        end
    end

    // Bus outputs
    assign rdata_o  = rdata_r;
    assign rvalid_o = rvalid_r;
    assign rerr_o   = rerr_r;
    assign ptr_o    = metering_address_pointer_r;

    assign zero_cross_filter_bypass_o = measure_config_a_r[A_ZX_BYPASS];
    assign integrator_enable_o = measure_config_a_r[A_INTEG];
    assign adc_channel_swap_o = measure_config_a_r[A_SWAP];
    assign adc_power_down_o = measure_config_a_r[A_ADC_POWER_DOWN];
    assign pulse_b_disable_o = measure_config_a_r[A_PB_DIS];
    assign pulse_a_disable_o = measure_config_a_r[A_PA_DIS];
    assign highpass_bypass_o = measure_config_a_r[A_HPF_BYPASS];

    assign pulse_a_source_o = pa_src_r;
    assign pulse_b_source_o = pb_src_r;
    assign apparent_accum_irms_o = measure_config_b_r[B_IRMS_SEL];
    assign rms_zero_cross_sync_o = measure_config_b_r[B_ZX_RMS];
    assign waveform_sampling_enable_o = measure_config_b_r[B_WAVE_EN];
    assign soft_reset_pulse_o = soft_reset_r;

    // Scaling outputs
    assign reactive_energy_scale_o   = reactive_energy_scale_r;
    assign apparent_energy_scale_o   = apparent_energy_scale_r;
    assign pulse_a_numerator_o       = pulse_a_numerator_r;
    assign pulse_a_denominator_o     = pulse_a_denominator_r;
    assign pulse_b_numerator_o       = pulse_b_numerator_r;
    assign pulse_b_denominator_o     = pulse_b_denominator_r;
    assign calibration_mode_select_o = calibration_mode_select_r;
endmodule

// *** emc_mode_config_checker.sv ***
// Checker: concurrent assertions on the mode config bank ports
`timescale 1ns/1ps
module emc_mode_config_checker
    import emc_pkg::*;
(
    // Clock, reset and register port
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              rvalid_o,
    input wire logic              rerr_o,
    input wire logic [ADDR_W-1:0] ptr_o,
    // Datapath controls
    input wire logic              zero_cross_filter_bypass_o,
    input wire logic              integrator_enable_o,
    input wire logic              adc_channel_swap_o,
    input wire logic              adc_power_down_o,
    input wire logic              pulse_b_disable_o,
    input wire logic              pulse_a_disable_o,
    input wire logic              highpass_bypass_o,
    input wire emc_src_t          pulse_a_source_o,
    input wire emc_src_t          pulse_b_source_o,
    input wire logic              apparent_accum_irms_o,
    input wire logic              rms_zero_cross_sync_o,
    input wire logic              waveform_sampling_enable_o,
    input wire logic              soft_reset_pulse_o,
    input wire logic [7:0]        reactive_energy_scale_o,
    input wire logic [15:0]       pulse_a_denominator_o
);
    // Write wins over a read in the same cycle
    wire logic       rd_go = rd_i && !wr_i;
    wire logic       wr_a  = wr_i && (ptr_o == ADDR_CFG_A);
    wire logic       wr_b  = wr_i && (ptr_o == ADDR_CFG_B);
    wire logic [6:0] ctl_a = {zero_cross_filter_bypass_o, integrator_enable_o,
        adc_channel_swap_o, adc_power_down_o, pulse_b_disable_o,
        pulse_a_disable_o, highpass_bypass_o};
    // Mapped addresses
    wire logic mapped = ptr_o inside {ADDR_PERIOD, ADDR_CFG_A, ADDR_CFG_B,
        [ADDR_VAR_SCALE:ADDR_PB_DEN], [ADDR_RSV_0:ADDR_RSV_3]};
    // Write data delayed
    logic [DATA_W-1:0] wd1_r;
    logic [DATA_W-1:0] wd2_r;
    always_ff @(posedge clk_i) begin
        wd1_r <= wdata_i;
        wd2_r <= wd1_r;
    end
    // A 1X code resolves to apparent power or current rms
    function automatic emc_src_t src_of(logic [1:0] s, logic irms);
        return s[1] ? emc_src_t'({1'b1, irms}) : emc_src_t'(s);
    endfunction
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_read_answer: assert property (rd_go |=> rvalid_o)
        else $error("read got no answer");
    a_idle_quiet: assert property (!rd_go |=> !rvalid_o && !rerr_o)
        else $error("answer without a read");
    a_unmapped_err: assert property (rd_go && !mapped |=> rerr_o
        && rdata_o == 16'h0000) else $error("unmapped read not flagged");
    a_cfg_a_bits: assert property (wr_a && !wdata_i[7] |=>
        ctl_a == wd1_r[6:0]) else $error("mode A controls wrong");
    a_soft_reset: assert property (wr_a && wdata_i[7] |=> soft_reset_pulse_o
        && ctl_a == 7'h06 && reactive_energy_scale_o == 8'h00
        && pulse_a_denominator_o == 16'h003f) else $error("soft reset failed");
    a_cfg_b_bits: assert property (wr_b |=> {apparent_accum_irms_o,
        rms_zero_cross_sync_o, waveform_sampling_enable_o} ==
        {wd1_r[3], wd1_r[2], wd1_r[0]}) else $error("mode B controls wrong");
    a_src_follow: assert property (wr_b ##1 !wr_b |=>
        pulse_a_source_o == src_of(wd2_r[5:4], wd2_r[3]) &&
        pulse_b_source_o == src_of(wd2_r[7:6], wd2_r[3]))
        else $error("pulse source decode wrong");
    a_scale_write: assert property (wr_i && ptr_o == ADDR_VAR_SCALE |=>
        reactive_energy_scale_o == wd1_r[7:0]) else $error("scale not written");
    a_reset_values: assert property ($fell(rst_i) |-> ctl_a == 7'h06
        && !waveform_sampling_enable_o && pulse_a_denominator_o == 16'h003f
        && pulse_b_source_o == EMC_SRC_REACTIVE) else $error("bad reset value");
endmodule

bind emc_mode_config emc_mode_config_checker chk_u (.*);

// *** emc_mcu_model.sv ***
// Model of the microcontroller side of the indirect register port
`timescale 1ns/1ps
module emc_mcu_model
    import emc_pkg::*;
(
    // Clock and answers from the bank
    input  wire logic              clk_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    input  wire logic              rvalid_i,
    input  wire logic              rerr_i,
    // Requests toward the bank
    output logic [ADDR_W-1:0]      ptr_wr_o,
    output logic [ADDR_W-1:0]      ptr_data_o,
    output logic                   wr_o,
    output logic                   rd_o,
    output logic [DATA_W-1:0]      wdata_o
);
    // Idle drive at time zero
    initial begin
        ptr_wr_o = 7'h00;
        ptr_data_o = 7'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'h0000;
    end
    task automatic set_ptr(input logic [ADDR_W-1:0] a);
        @(negedge clk_i);
        ptr_wr_o = 7'h7f;
        ptr_data_o = a;
        @(negedge clk_i);
        ptr_wr_o = 7'h00;
        // Released lines show the inverse
        ptr_data_o = ~a;
    endtask
    // Write one word over one sampling edge; reserved addresses are skipped
    task automatic wr_reg(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        if (a inside {ADDR_RSV_0, ADDR_RSV_1, ADDR_RSV_2, ADDR_RSV_3}) return;
        set_ptr(a);
        wr_o = 1'b1;
        // one shared rms bit, so no split setup
        wdata_o = d;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    // Read one word
    task automatic rd_reg(input logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d, output logic e);
        set_ptr(a);
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        d = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
        e = (rvalid_i === 1'b1) ? rerr_i : 1'bx;
    endtask
endmodule

// *** tb_emc_mode_config.sv ***
// Self-checking bench for the mode config register bank
`timescale 1ns/1ps
module tb_emc_mode_config;
    import emc_pkg::*;
    // Clock, reset and bookkeeping
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    int                fails = 0;
    int                checked = 0;
    int                cycles = 0;
    logic [15:0]       rd_d;
    logic              rd_e;
    // Port between model and bank
    logic [ADDR_W-1:0] ptr_wr, ptr_data;
    logic              wr, rd, rvalid, rerr;
    logic [DATA_W-1:0] wdata, rdata;
    // Measurements from the datapath, steady
    logic [15:0]       per_in = 16'h1f40;
    logic [15:0]       frq_in = 16'h0c80;
    // Bank outputs
    logic [6:0]        ctl_a;
    emc_src_t          src_a, src_b;
    logic              irms, zxs, wav;
    logic [7:0]        var_sc, cal;
    logic [15:0]       b_den;

    emc_mode_config dut_u (.clk_i(clk_i), .rst_i(rst_i), .ptr_wr_i(ptr_wr),
        .ptr_data_i(ptr_data), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
        .rdata_o(rdata), .rvalid_o(rvalid), .rerr_o(rerr), .ptr_o(),
        .line_period_i(per_in), .line_freq_i(frq_in),
        .zero_cross_filter_bypass_o(ctl_a[6]), .integrator_enable_o(ctl_a[5]),
        .adc_channel_swap_o(ctl_a[4]), .adc_power_down_o(ctl_a[3]),
        .pulse_b_disable_o(ctl_a[2]), .pulse_a_disable_o(ctl_a[1]),
        .highpass_bypass_o(ctl_a[0]), .pulse_a_source_o(src_a),
        .pulse_b_source_o(src_b), .apparent_accum_irms_o(irms),
        .rms_zero_cross_sync_o(zxs), .waveform_sampling_enable_o(wav),
        .soft_reset_pulse_o(), .reactive_energy_scale_o(var_sc),
        .apparent_energy_scale_o(), .pulse_a_numerator_o(),
        .pulse_a_denominator_o(), .pulse_b_numerator_o(),
        .pulse_b_denominator_o(b_den), .calibration_mode_select_o(cal));
    emc_mcu_model mcu_u (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
        .rerr_i(rerr), .ptr_wr_o(ptr_wr), .ptr_data_o(ptr_data), .wr_o(wr),
        .rd_o(rd), .wdata_o(wdata));

    // 100 ns clock
    initial forever #50 clk_i = ~clk_i;
    // Hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Reset values and an unmapped read
    task automatic t_defaults();
        logic [6:0]  ad [13] = '{7'h0b, 7'h0c, 7'h25, 7'h26, 7'h27, 7'h28,
            7'h29, 7'h2a, 7'h3b, 7'h3c, 7'h3d, 7'h3e, 7'h3f};
        logic [15:0] ex [13] = '{16'h6, 16'h40, 16'h0, 16'h0, 16'h0, 16'h3f,
            16'h0, 16'h3f, 16'h0, 16'h300, 16'h0, 16'h0, 16'h0};
        for (int i = 0; i < 13; i++) begin
            mcu_u.rd_reg(ad[i], rd_d, rd_e);
            chk(rd_d, ex[i]);
        end
        chk({src_b, src_a, 5'h0, ctl_a}, 16'h4006);
        mcu_u.wr_reg(7'h7f, 16'hffff);
        mcu_u.rd_reg(7'h7f, rd_d, rd_e);
        chk({rd_e, rd_d[14:0]}, 16'h8000);
    endtask
    // Writable words read back; byte registers keep the low byte
    task automatic t_readback();
        logic [6:0] ad [7] = '{7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h3d};
        logic [15:0] v;
        for (int i = 0; i < 7; i++) begin
            v = 16'ha5c3 ^ {i[7:0], 8'h00};
            mcu_u.wr_reg(ad[i], v);
            mcu_u.rd_reg(ad[i], rd_d, rd_e);
            chk(rd_d, (i < 2 || i == 6) ? {8'h00, v[7:0]} : v);
        end
        chk({var_sc, cal}, 16'hc3c3);
        chk(b_den, 16'ha0c3);
    endtask
    // Soft reset after the words were changed
    task automatic t_soft_reset();
        mcu_u.wr_reg(ADDR_CFG_A, 16'h0080);
        mcu_u.rd_reg(ADDR_CFG_A, rd_d, rd_e);
        chk(rd_d, 16'h0006);
        mcu_u.rd_reg(ADDR_PA_DEN, rd_d, rd_e);
        chk(rd_d, 16'h003f);
        chk({var_sc, cal}, 16'h0000);
        chk(b_den, 16'h003f);
    endtask
    // Walking one through the low seven mode A bits
    task automatic t_cfg_a();
        for (int b = 0; b < 7; b++) begin
            mcu_u.wr_reg(ADDR_CFG_A, 16'h0001 << b);
            chk({9'h000, ctl_a}, 16'h0001 << b);
        end
    endtask
    // Every source code pair with both rms selections
    task automatic t_sources();
        logic [7:0] d;
        emc_src_t   ea, eb;
        for (int i = 0; i < 32; i++) begin
            d = {i[3:0], i[4], i[0], 1'b0, i[1]};
            ea = d[5] ? emc_src_t'({1'b1, d[3]}) : emc_src_t'(d[5:4]);
            eb = d[7] ? emc_src_t'({1'b1, d[3]}) : emc_src_t'(d[7:6]);
            mcu_u.wr_reg(ADDR_CFG_B, {8'h00, d});
            @(negedge clk_i);
            chk({12'h000, eb, ea}, {12'h000, src_b, src_a});
            chk({13'h0, irms, zxs, wav}, {13'h0, d[3:2], d[0]});
        end
    endtask
    // Period or frequency behind the same address
    task automatic t_period();
        mcu_u.wr_reg(ADDR_CFG_B, 16'h0040);
        mcu_u.rd_reg(ADDR_PERIOD, rd_d, rd_e);
        chk(rd_d, per_in);
        mcu_u.wr_reg(ADDR_CFG_B, 16'h0042);
        mcu_u.rd_reg(ADDR_PERIOD, rd_d, rd_e);
        chk(rd_d, frq_in);
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        @(negedge clk_i) rst_i = 1'b0;
        t_defaults();
        t_readback();
        t_soft_reset();
        t_cfg_a();
        t_sources();
        t_period();
        wrap_up();
    end
endmodule
